/* inc/dmsc_consts.vh */
`ifndef DMSC_CONSTS_VH
`define DMSC_CONSTS_VH
// ****************************************
// register byte addresses
// ****************************************
`define DMSC_ADDR_SETPOINT   8'h00
`define DMSC_ADDR_DIRECTION  8'h04
`define DMSC_ADDR_SPEED      8'h08
`define DMSC_ADDR_DUTY       8'h0c
`define DMSC_ADDR_STATUS     8'h10
`define DMSC_ADDR_MASK       8'h14
`define DMSC_ADDR_CONTROL    8'h18
// ****************************************
// field positions
// ****************************************
`define DMSC_SET_LEFT_LSB    0
`define DMSC_SET_RIGHT_LSB   8
`define DMSC_DIR_REQ_LSB     0
`define DMSC_DIR_ACT_LSB     8
`define DMSC_CTL_UPDATE_BIT  0
`define DMSC_ST_OVERCURRENT  0
`define DMSC_ST_SHUTDOWN     1
`define DMSC_ST_FAILURE      2
`define DMSC_ST_NO_SUPPLY    3
`define DMSC_ST_WINDOW       4
// ****************************************
// direction codes and reset values
// ****************************************
`define DMSC_DIR_FORWARD     2'h0
`define DMSC_DIR_BACKWARD    2'h1
`define DMSC_DIR_ROT_LEFT    2'h2
`define DMSC_DIR_ROT_RIGHT   2'h3
`define DMSC_RST_DIRECTION   2'h0
`define DMSC_RST_MASK        5'h00
// ****************************************
// timing
// ****************************************
`define DMSC_CLK_HZ          25000000
`define DMSC_WINDOW_MS       200
`define DMSC_WINDOW_CYC      ((`DMSC_CLK_HZ / 1000) * `DMSC_WINDOW_MS)
`define DMSC_OC_SPAN_S       20
`define DMSC_OC_SPAN_WIN     ((`DMSC_OC_SPAN_S * 1000) / `DMSC_WINDOW_MS)
`define DMSC_OC_LIMIT        3
`define DMSC_FAIL_WINDOWS    5
`define DMSC_START_WINDOWS   2
`endif

/* hdl/dmsc_seg_counter.v */
`default_nettype none
`include "dmsc_consts.vh"
// counts rising encoder edges; snapshot at each window end
module dmsc_seg_counter #(
   parameter W = 8
) (
   // clock and reset
   input  wire         core_clk,
   input  wire         rst,
   // encoder and window
   input  wire         enc,
   input  wire         win_end,
   output reg  [W-1:0] speed_q
);
   reg         enc_q;
   reg [W-1:0] cnt_q;
   wire        rise = enc & ~enc_q;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enc_q   <= 1'b0;
         cnt_q   <= {W{1'b0}};
         speed_q <= {W{1'b0}};
      end else begin
         enc_q <= enc;
         if (win_end) begin
            speed_q <= cnt_q;
            cnt_q   <= {{(W-1){1'b0}}, rise};
         end else if (rise && cnt_q != {W{1'b1}}) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule
`default_nettype wire

/* hdl/dmsc_pwm.v */
`default_nettype none
`include "dmsc_consts.vh"
// free-running pwm; output low whenever disabled
module dmsc_pwm #(
   parameter W = 8
) (
   // clock and reset
   input  wire         core_clk,
   input  wire         rst,
   // control
   input  wire         enable,
   input  wire [W-1:0] duty,
   output reg          pwm_q
);
   reg [W-1:0] ramp_q;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ramp_q <= {W{1'b0}};
         pwm_q  <= 1'b0;
      end else begin
         ramp_q <= ramp_q + {{(W-1){1'b0}}, 1'b1};
         pwm_q  <= enable && (ramp_q < duty);
      end
   end
endmodule
`default_nettype wire

/* hdl/dmsc_speed_ctrl.v */
// Our own choices: the register addresses and the Wishbone interface to the registers.
`default_nettype none
`include "dmsc_consts.vh"
// Function
// - Encoder segments of each motor are counted over a 200 ms window, giving speed per window.
// - Each window with a pending update request, the setpoint-minus-speed error is accumulated into that motor's pwm duty.
// - A direction change ramps to zero, switches direction, then returns to the setpoint.
// - An overcurrent indication on either motor stops the motors.
// - Three overcurrent events within 20 s latch a shutdown that flashes four indicators.
// - Duty at maximum without matching measured speed is a failure that halts both motors.
// - Both setpoints at zero decelerate the motors and then disable the pwm outputs.
// - Left and right setpoints are independent, regulated separately and readable back.
// - Measured left and right speeds are readable in segments per window.
// - Direction takes forward, backward, rotate left or rotate right, and the active one reads.
// - Regulation runs at most once per window; extra update requests do nothing.
// - After reset the direction is forward.
// - Without sensor supply the motors stop after a short start attempt and indicators flash.
module dmsc_speed_ctrl #(
   parameter W          = 8,
   parameter WINDOW_CYC = `DMSC_WINDOW_CYC,
   parameter FLASH_CYC  = `DMSC_WINDOW_CYC
) (
   // clock and reset
   input  wire          core_clk,
   input  wire          rst,
   // classic wishbone slave
   input  wire          wb_cyc_i,
   input  wire          wb_stb_i,
   input  wire          wb_we_i,
   input  wire [7:0]    wb_adr_i,
   input  wire [3:0]    wb_sel_i,
   input  wire [31:0]   wb_dat_i,
   output reg  [31:0]   wb_dat_o,
   output reg           wb_ack_o,
   // motor side
   input  wire          enc_left,
   input  wire          enc_right,
   input  wire          overcurrent_left,
   input  wire          overcurrent_right,
   input  wire          sensor_supply_on,
   output reg           pwm_left_q,
   output reg           pwm_right_q,
   output reg  [1:0]    motor_dir_q,
   output reg  [3:0]    status_led_q,
   output reg           irq_q
);
   // ****************************************
   // states and locals
   // ****************************************
   localparam ST_RUN  = 2'h0;
   localparam ST_RAMP = 2'h1;
   localparam ST_OFF  = 2'h2;
   localparam ST_HALT = 2'h3;
   localparam [31:0] WIN_M1 = WINDOW_CYC - 1;
   localparam [31:0] FLASH_M1 = FLASH_CYC - 1;
   localparam A = W + 2;

   reg  [1:0]   state_q;
   reg  [31:0]  win_cnt_q;
   reg          win_end_q;
   reg  [31:0]  flash_cnt_q;
   reg          flash_q;
   reg  [W-1:0] set_left_q;
   reg  [W-1:0] set_right_q;
   reg  [1:0]   dir_req_q;
   reg  [1:0]   dir_act_q;
   reg          update_pend_q;
   reg  [W-1:0] duty_left_q;
   reg  [W-1:0] duty_right_q;
   reg  [4:0]   status_q;
   reg  [4:0]   mask_q;
   reg  [1:0]   oc_count_q;
   reg  [7:0]   oc_span_q;
   reg  [3:0]   fail_cnt_q;
   reg  [3:0]   start_cnt_q;
   reg          shutdown_q;
   reg          oc_prev_q;
   wire [W-1:0] speed_left;
   wire [W-1:0] speed_right;
   wire         pwm_l;
   wire         pwm_r;
   wire         oc_now = overcurrent_left | overcurrent_right;
   wire         oc_evt = oc_now & ~oc_prev_q;
   wire         wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire         wb_wr  = wb_req & wb_we_i;
   wire         pwm_en = (state_q == ST_RUN || state_q == ST_RAMP) && !oc_now;
   // one regulation step per window however many requests arrived
   wire         tick   = win_end_q & update_pend_q;

   // ****************************************
   // measurement window and flash timer
   // ****************************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         win_cnt_q   <= 32'h0;
         win_end_q   <= 1'b0;
         flash_cnt_q <= 32'h0;
         flash_q     <= 1'b1;
      end else begin
         win_end_q <= (win_cnt_q == WIN_M1);
         if (win_cnt_q == WIN_M1)
            win_cnt_q <= 32'h0;
         else
            win_cnt_q <= win_cnt_q + 32'h1;
         // blink phase restarts at shutdown, so the first flash is a full one
         if (!shutdown_q) begin
            flash_cnt_q <= 32'h0;
            flash_q     <= 1'b1;
         end else if (flash_cnt_q == FLASH_M1) begin
            flash_cnt_q <= 32'h0;
            flash_q     <= ~flash_q;
         end else begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
         end
      end
   end

   // both counters share one window strobe so left and right compare fairly
   dmsc_seg_counter #(.W(W)) u_cnt_left (
      .core_clk (core_clk),
      .rst      (rst),
      .enc      (enc_left),
      .win_end  (win_end_q),
      .speed_q  (speed_left)
   );
   dmsc_seg_counter #(.W(W)) u_cnt_right (
      .core_clk (core_clk),
      .rst      (rst),
      .enc      (enc_right),
      .win_end  (win_end_q),
      .speed_q  (speed_right)
   );

   // ****************************************
   // integrator with saturation
   // ****************************************
   // speed in use is the last window's count: one window of loop lag
   function [W-1:0] integrate;
      input [W-1:0] duty;
      input [W-1:0] target;
      input [W-1:0] meas;
      reg signed [A-1:0] sum;
      begin
         sum = $signed({2'b00, duty}) + $signed({2'b00, target})
               - $signed({2'b00, meas});
         if (sum < 0)
            integrate = {W{1'b0}};
         else if (sum > $signed({2'b00, {W{1'b1}}}))
            integrate = {W{1'b1}};
         else
            integrate = sum[W-1:0];
      end
   endfunction

   // ramp target is zero while reversing or stopping
   wire         to_zero = (state_q == ST_RAMP) || (state_q == ST_OFF);
   wire [W-1:0] tgt_l   = to_zero ? {W{1'b0}} : set_left_q;
   wire [W-1:0] tgt_r   = to_zero ? {W{1'b0}} : set_right_q;
   wire         stopped = (speed_left == {W{1'b0}}) && (speed_right == {W{1'b0}});
   wire         set_zero = (set_left_q == {W{1'b0}}) && (set_right_q == {W{1'b0}});
   // duty pinned high while the wheel barely moves
   wire         stall = (duty_left_q == {W{1'b1}} && speed_left < (set_left_q >> 2)) ||
                        (duty_right_q == {W{1'b1}} && speed_right < (set_right_q >> 2));

   // ****************************************
   // regulation state machine
   // ****************************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q      <= ST_OFF;
         dir_act_q    <= `DMSC_RST_DIRECTION;
         duty_left_q  <= {W{1'b0}};
         duty_right_q <= {W{1'b0}};
         fail_cnt_q   <= 4'h0;
         start_cnt_q  <= 4'h0;
      end else if (shutdown_q) begin
         state_q      <= ST_HALT;
         duty_left_q  <= {W{1'b0}};
         duty_right_q <= {W{1'b0}};
      // regulation stops and both duties clear to zero under overcurrent; the pending request is spent
      end else if (oc_now) begin
         duty_left_q  <= {W{1'b0}};
         duty_right_q <= {W{1'b0}};
      end else if (tick) begin
         duty_left_q  <= integrate(duty_left_q, tgt_l, speed_left);
         duty_right_q <= integrate(duty_right_q, tgt_r, speed_right);
         fail_cnt_q   <= stall ? fail_cnt_q + 4'h1 : 4'h0;
         if (!sensor_supply_on && state_q == ST_RUN)
            start_cnt_q <= start_cnt_q + 4'h1;
         else
            start_cnt_q <= 4'h0;
         case (state_q)
            ST_OFF: begin
               duty_left_q  <= {W{1'b0}};
               duty_right_q <= {W{1'b0}};
               if (!set_zero)
                  state_q <= (dir_req_q != dir_act_q) ? ST_RAMP : ST_RUN;
            end
            ST_RUN: begin
               if (dir_req_q != dir_act_q || set_zero)
                  state_q <= ST_RAMP;
            end
            ST_RAMP: begin
               if (stopped && duty_left_q == {W{1'b0}} && duty_right_q == {W{1'b0}}) begin
                  dir_act_q <= dir_req_q;
                  state_q   <= set_zero ? ST_OFF : ST_RUN;
               end
            end
            default: state_q <= ST_HALT;
         endcase
      end
   end

   // pwm period is 2**W cycles; a window of whole periods avoids beats in counts
   dmsc_pwm #(.W(W)) u_pwm_left (
      .core_clk (core_clk),
      .rst      (rst),
      .enable   (pwm_en),
      .duty     (duty_left_q),
      .pwm_q    (pwm_l)
   );
   dmsc_pwm #(.W(W)) u_pwm_right (
      .core_clk (core_clk),
      .rst      (rst),
      .enable   (pwm_en),
      .duty     (duty_right_q),
      .pwm_q    (pwm_r)
   );

   // ****************************************
   // protection: overcurrent history and shutdown
   // ****************************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         oc_prev_q  <= 1'b0;
         oc_count_q <= 2'h0;
         oc_span_q  <= 8'h0;
         shutdown_q <= 1'b0;
      end else begin
         oc_prev_q <= oc_now;
         // span restarts at the first event of a group
         if (oc_evt) begin
            oc_count_q <= oc_count_q + 2'h1;
            if (oc_count_q == 2'h0)
               oc_span_q <= 8'h0;
            if (oc_count_q == `DMSC_OC_LIMIT - 1)
               shutdown_q <= 1'b1;
         end else if (win_end_q && oc_count_q != 2'h0) begin
            if (oc_span_q == `DMSC_OC_SPAN_WIN - 1)
               oc_count_q <= 2'h0;
            else
               oc_span_q <= oc_span_q + 8'h1;
         end
         // latched causes; only reset clears the shutdown
         if (fail_cnt_q == `DMSC_FAIL_WINDOWS)
            shutdown_q <= 1'b1;
         if (start_cnt_q == `DMSC_START_WINDOWS)
            shutdown_q <= 1'b1;
      end
   end

   // ****************************************
   // wishbone registers and interrupt
   // ****************************************
   // registered ack gives one wait state; writes land on the taking edge
   wire [4:0] events = {win_end_q, ~sensor_supply_on & shutdown_q,
                        fail_cnt_q == `DMSC_FAIL_WINDOWS, shutdown_q, oc_evt};
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h0;
         set_left_q    <= {W{1'b0}};
         set_right_q   <= {W{1'b0}};
         dir_req_q     <= `DMSC_RST_DIRECTION;
         update_pend_q <= 1'b0;
         status_q      <= 5'h00;
         mask_q        <= `DMSC_RST_MASK;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0;
         // a request in the tick cycle is kept for the next window
         if (tick)
            update_pend_q <= 1'b0;
         // sets win over a simultaneous clear
         status_q <= (status_q & ~((wb_wr && wb_adr_i == `DMSC_ADDR_STATUS && wb_sel_i[0])
                     ? wb_dat_i[4:0] : 5'h00)) | events;
         if (wb_wr) begin
            case (wb_adr_i)
               `DMSC_ADDR_SETPOINT: begin
                  if (wb_sel_i[0]) set_left_q  <= wb_dat_i[`DMSC_SET_LEFT_LSB +: W];
                  if (wb_sel_i[1]) set_right_q <= wb_dat_i[`DMSC_SET_RIGHT_LSB +: W];
               end
               `DMSC_ADDR_DIRECTION:
                  if (wb_sel_i[0]) dir_req_q <= wb_dat_i[1:0];
               `DMSC_ADDR_MASK:
                  if (wb_sel_i[0]) mask_q <= wb_dat_i[4:0];
               `DMSC_ADDR_CONTROL:
                  if (wb_sel_i[0] && wb_dat_i[`DMSC_CTL_UPDATE_BIT])
                     update_pend_q <= 1'b1;
               default: ;
            endcase
         end else if (wb_req) begin
            case (wb_adr_i)
               `DMSC_ADDR_SETPOINT:
                  wb_dat_o <= {16'h0, set_right_q, set_left_q};
               `DMSC_ADDR_DIRECTION:
                  wb_dat_o <= {22'h0, dir_act_q, 6'h0, dir_req_q};
               `DMSC_ADDR_SPEED:
                  wb_dat_o <= {16'h0, speed_right, speed_left};
               `DMSC_ADDR_DUTY:
                  wb_dat_o <= {16'h0, duty_right_q, duty_left_q};
               `DMSC_ADDR_STATUS:
                  wb_dat_o <= {22'h0, state_q, 3'h0, status_q};
               `DMSC_ADDR_MASK:
                  wb_dat_o <= {27'h0, mask_q};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   // ****************************************
   // registered outputs
   // ****************************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pwm_left_q   <= 1'b0;
         pwm_right_q  <= 1'b0;
         motor_dir_q  <= `DMSC_RST_DIRECTION;
         status_led_q <= 4'h0;
         irq_q        <= 1'b0;
      end else begin
         // shutdown gates the pins directly, not through the duty path
         pwm_left_q   <= pwm_l & ~shutdown_q;
         pwm_right_q  <= pwm_r & ~shutdown_q;
         motor_dir_q  <= dir_act_q;
         status_led_q <= shutdown_q ? {4{flash_q}} : 4'h0;
         irq_q        <= |(status_q & mask_q);
      end
   end
endmodule
`default_nettype wire

/* verification/dmsc_asserts.sv */
`default_nettype none
`include "dmsc_consts.vh"
module dmsc_asserts (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // motor side
   input wire logic        overcurrent_left,
   input wire logic        overcurrent_right,
   input wire logic        pwm_left_q,
   input wire logic        pwm_right_q,
   input wire logic [1:0]  motor_dir_q,
   input wire logic [3:0]  status_led_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic pwm_off = !pwm_left_q && !pwm_right_q;
   wire logic oc_any  = overcurrent_left || overcurrent_right;
   // ****************************************
   // properties
   // ****************************************
   ack_answer_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   ack_pulse_a: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   dat_quiet_a: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   // two register stages from sense input to pin allow a short lag
   oc_stop_a: assert property (
      oc_any [*4] |-> pwm_off) else $error("pwm on during overcurrent");
   led_pair_a: assert property (
      status_led_q == 4'h0 || status_led_q == 4'hf) else $error("leds not together");
   led_hold_a: assert property (
      $changed(status_led_q) |=> $stable(status_led_q) [*8]) else $error("led flicker");
   halt_pwm_a: assert property (
      status_led_q != 4'h0 |-> pwm_off) else $error("pwm on in shutdown");
   dir_switch_a: assert property (
      $changed(motor_dir_q) |-> pwm_off) else $error("direction flipped while driven");
   dir_reset_a: assert property (
      $fell(rst) |-> motor_dir_q == `DMSC_DIR_FORWARD && pwm_off) else $error("bad reset");
   cover property ($rose(status_led_q[0]));
   cover property ($changed(motor_dir_q));
   cover property (oc_any && pwm_off);
endmodule
bind dmsc_speed_ctrl dmsc_asserts chk_u (
   .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .overcurrent_left(overcurrent_left),
   .overcurrent_right(overcurrent_right), .pwm_left_q(pwm_left_q),
   .pwm_right_q(pwm_right_q), .motor_dir_q(motor_dir_q), .status_led_q(status_led_q));
`default_nettype wire

/* verification/dmsc_motor_model.sv */
`default_nettype none
// one encoder rise per two driven cycles; stall models a dead encoder
module dmsc_motor_model (
   // clock
   input  wire logic core_clk,
   // drive and fault
   input  wire logic pwm,
   input  wire logic stall,
   output var  logic enc
);
   timeunit 1ns;
   timeprecision 1ps;
   initial enc = 1'b0;
   always @(posedge core_clk) begin
      if (pwm && !stall)
         enc <= ~enc;
   end
endmodule
`default_nettype wire

/* verification/dual_motor_speed_control_bench.sv */
`default_nettype none
`include "dmsc_consts.vh"
module dual_motor_speed_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] a; logic [3:0] s; logic [31:0] d, e, m;} dmsc_row_t;
   localparam logic [7:0] SP = `DMSC_ADDR_SETPOINT;
   localparam logic [7:0] DR = `DMSC_ADDR_DIRECTION;
   localparam logic [7:0] SD = `DMSC_ADDR_SPEED;
   localparam logic [7:0] DU = `DMSC_ADDR_DUTY;
   localparam logic [7:0] ST = `DMSC_ADDR_STATUS;
   localparam logic [7:0] MK = `DMSC_ADDR_MASK;
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        cyc      = 1'b0;
   logic        we       = 1'b0;
   logic [7:0]  adr      = 8'h00;
   logic [3:0]  sel      = 4'h0;
   logic [31:0] wd       = 32'h0;
   logic        oc_l     = 1'b0;
   logic        oc_r     = 1'b0;
   logic        supply   = 1'b1;
   logic        stall    = 1'b0;
   logic [31:0] rd, d0;
   wire  [31:0] dat_o;
   wire         ack, pwm_l, pwm_r, enc_l, enc_r, irq;
   wire  [1:0]  dir;
   wire  [3:0]  led;
   int          errors  = 0;
   int          n_tests = 0;
   int          kp, kl;
   dmsc_row_t   rows [7] = '{
      '{SP, 4'hf, 32'h4632, 32'h4632, 32'hffff},
      '{SP, 4'h1, 32'hff10, 32'h4610, 32'hffff},
      '{MK, 4'hf, 32'hffffffff, 32'h1f, 32'h1f},
      '{MK, 4'hf, 32'h1, 32'h1, 32'h1f},
      '{SD, 4'hf, 32'hffff, 32'h0, 32'hffff},
      '{8'h1c, 4'hf, 32'hffffffff, 32'h0, 32'hffffffff},
      '{DR, 4'hf, 32'h2, 32'h2, 32'h3}};
   // small window keeps the run short; whole pwm periods per window keep counts steady
   dmsc_speed_ctrl #(.WINDOW_CYC(256), .FLASH_CYC(50)) dut_u (
      .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .enc_left(enc_l), .enc_right(enc_r), .overcurrent_left(oc_l),
      .overcurrent_right(oc_r), .sensor_supply_on(supply), .pwm_left_q(pwm_l),
      .pwm_right_q(pwm_r), .motor_dir_q(dir), .status_led_q(led), .irq_q(irq));
   dmsc_motor_model mot_l (.core_clk(core_clk), .pwm(pwm_l), .stall(stall), .enc(enc_l));
   dmsc_motor_model mot_r (.core_clk(core_clk), .pwm(pwm_r), .stall(stall), .enc(enc_r));
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      sel <= s;
      do @(posedge core_clk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      we  <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hf);
   endtask
   task automatic get(input logic [7:0] a);
      wb(1'b0, a, 32'h0, 4'hf);
   endtask
   // two requests per window; the second must merge
   task automatic run(input int n);
      repeat (2 * n) begin
         put(`DMSC_ADDR_CONTROL, 32'h1);
         repeat (125) @(posedge core_clk);
      end
   endtask
   task automatic watch(input int n);
      kp = 0;
      kl = 0;
      repeat (n) begin
         @(posedge core_clk);
         if (pwm_l !== 1'b0 || pwm_r !== 1'b0) kp++;
         if (led !== 4'h0) kl++;
      end
   endtask
   task automatic reset_dut;
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
   endtask
   function automatic logic near(input logic [7:0] g, input logic [7:0] e);
      return ((g > e) ? g - e : e - g) <= 8'h8;
   endfunction
   task automatic finish_test;
      $display("errors %0d of %0d checks", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ****************************************
   // stimulus
   // ****************************************
   initial forever #20 core_clk = ~core_clk;
   initial begin
      repeat (100000) @(posedge core_clk);
      errors++;
      finish_test;
   end
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      get(DR); chk(rd, 32'h0);
      foreach (rows[i]) begin
         wb(1'b1, rows[i].a, rows[i].d, rows[i].s);
         get(rows[i].a); chk(rd & rows[i].m, rows[i].e);
      end
      put(SP, 32'h3c28); run(30);
      get(SD); chk(near(rd[7:0], 8'd40) && near(rd[15:8], 8'd60), 1);
      repeat (250) @(posedge core_clk);
      get(DU); d0 = rd;
      repeat (600) @(posedge core_clk);
      get(DU); chk(rd, d0);
      put(SP, 32'hc8c8); run(12);
      get(DU); chk(rd[15:0], 16'hffff);
      put(SP, 32'h2828);
      for (int c = 1; c < 5; c++) begin
         put(DR, c % 4); run(30);
         get(DR); chk(rd[9:8], c % 4);
         chk(dir, c % 4);
         get(SD); chk(near(rd[7:0], 8'd40), 1);
      end
      put(SP, 32'h0); run(30);
      get(ST); chk(rd[9:8], 2'h2);
      watch(300); chk(kp, 0);
      put(SP, 32'h2828); run(10);
      put(ST, 32'h1f); repeat (3) @(posedge core_clk);
      chk(irq, 1'b0);
      oc_l <= 1'b1; repeat (5) @(posedge core_clk);
      watch(15); chk(kp, 0);
      oc_l <= 1'b0; repeat (3) @(posedge core_clk);
      chk(irq, 1'b1);
      get(ST); chk(rd[0], 1'b1);
      put(ST, 32'h1); repeat (3) @(posedge core_clk);
      chk(irq, 1'b0);
      repeat (2) begin
         run(2);
         oc_r <= 1'b1; repeat (20) @(posedge core_clk);
         oc_r <= 1'b0;
      end
      run(2);
      get(ST); chk(rd[1], 1'b1);
      put(SP, 32'h5050);
      watch(400); chk(kp, 0);
      chk(kl > 100 && kl < 300, 1);
      reset_dut; chk(led, 4'h0);
      stall <= 1'b1; put(SP, 32'h2828); run(20);
      get(ST); chk(rd[2], 1'b1);
      watch(300); chk(kp, 0);
      stall <= 1'b0; reset_dut;
      supply <= 1'b0; put(SP, 32'h2828); run(6);
      get(ST); chk(rd[3], 1'b1);
      watch(300); chk(kp == 0 && kl > 0, 1);
      finish_test;
   end
endmodule
`default_nettype wire
